// *** phymr_top.sv ***
/*
 * phy side of the mac interface: receive data/valid/error, transmit enable
 * and control decode, collision and carrier sense, for mii, gmii and rgmii.
 * assumes line-side receive words and mode/speed/duplex straps on I_MCLK;
 * mac pins (gtx clock, transmit pins) are asynchronous and synchronised here.
 */
// Function
// - gmii drives rx data bits 4-7
// - rgmii tx control carries enable and error
// - rx valid marks valid mii/gmii data
// - rgmii rx control combines valid and error
// - rx error high on error, non-rgmii
// - rgmii leaves rx error pin unused
// - half duplex collision on simultaneous activity
// - full duplex keeps collision low
// - rgmii leaves collision unused
// - half duplex carrier sense on rx/tx
// - 10/100 full duplex sense on rx only
// - rgmii leaves carrier sense unused
// - receive clock rate follows link speed
// - mii tx clock driven at 2.5/25 MHz
`timescale 1ns/1ps
module phymr_top
    import phymr_pkg::*;
#(
    parameter int HALF10   = phymr_pkg::PHYMR_HALF10,
    parameter int HALF100  = phymr_pkg::PHYMR_HALF100,
    parameter int HALF1000 = phymr_pkg::PHYMR_HALF1000
)(
    // clock and reset
    input  wire logic                      I_MCLK,
    input  wire logic                      I_SYS_RST,
    // configuration
    input  wire phymr_pkg::phymr_mode_t    I_MODE,
    input  wire phymr_pkg::phymr_speed_t   I_SPEED,
    input  wire logic                      I_FULL_DUPLEX,
    // line side
    input  wire phymr_pkg::phymr_rx_line_t I_LINE_RX,
    output phymr_pkg::phymr_tx_word_t      O_TX,
    output logic                           O_TX_STROBE,
    // mac transmit pins
    input  wire logic                      I_GTX_CLK,
    input  wire logic                      I_TX_EN_CTRL,
    input  wire logic                      I_TX_ER,
    input  wire logic [7:0]                I_TXD,
    // mac receive pins
    output logic                           O_RX_CLK,
    output logic                           O_TX_CLK,
    output logic [7:0]                     O_RXD,
    output logic                           O_RX_DV_CTRL,
    output logic                           O_RX_ER,
    output logic                           O_COL,
    output logic                           O_CRS
);
    import phymr_pkg::*;

    // =====================================================
    // elaboration checks
    if (HALF10 < 1 || HALF100 < 1 || HALF1000 < 1 ||
        HALF10 > 255 || HALF100 > 255 || HALF1000 > 255)
    begin : g_bad_div
        $error("half period counts must lie in 1..255");
    end

    // =====================================================
    // clock divider
    logic [PHYMR_DIV_W-1:0] div_cnt_q;
    logic [PHYMR_DIV_W-1:0] div_cnt_d;
    logic [PHYMR_DIV_W-1:0] half_sel;
    logic                   clk_q;
    logic                   clk_d;
    logic                   rise_en;
    logic                   fall_en;

    always_comb
    begin
        case (I_SPEED)
            PHYMR_S10:   half_sel = PHYMR_DIV_W'(HALF10);
            PHYMR_S100:  half_sel = PHYMR_DIV_W'(HALF100);
            PHYMR_S1000: half_sel = PHYMR_DIV_W'(HALF1000);
            default:     half_sel = PHYMR_DIV_W'(HALF100);
        endcase
    end

    always_comb
    begin
        div_cnt_d = div_cnt_q + PHYMR_DIV_ONE;
        clk_d     = clk_q;
        rise_en   = 1'b0;
        fall_en   = 1'b0;
        if (div_cnt_q >= half_sel - PHYMR_DIV_ONE)
        begin
            div_cnt_d = PHYMR_DIV_ZERO;
            clk_d     = ~clk_q;
            rise_en   = ~clk_q;
            fall_en   = clk_q;
        end
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            div_cnt_q <= PHYMR_DIV_ZERO;
            clk_q     <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            clk_q     <= clk_d;
        end
    end

    assign O_RX_CLK = clk_q;
    assign O_TX_CLK = (I_MODE == PHYMR_MII) ? clk_q : 1'b0;

    // =====================================================
    // receive path
    phymr_rx_line_t   hold_q;
    phymr_rx_line_t   hold_d;
    logic [7:0]       rxd_q;
    logic [7:0]       rxd_d;
    logic             dv_q;
    logic             dv_d;
    logic             er_q;
    logic             er_d;

    always_comb
    begin
        hold_d = hold_q;
        rxd_d  = rxd_q;
        dv_d   = dv_q;
        er_d   = er_q;
        case (I_MODE)
            PHYMR_MII:
            begin
                if (fall_en)
                begin
                    rxd_d = {PHYMR_NIB_ZERO, I_LINE_RX.data[3:0]};
                    dv_d  = I_LINE_RX.valid;
                    er_d  = I_LINE_RX.err;
                end
            end
            PHYMR_GMII:
            begin
                if (fall_en)
                begin
                    rxd_d = I_LINE_RX.data;
                    dv_d  = I_LINE_RX.valid;
                    er_d  = I_LINE_RX.err;
                end
            end
            PHYMR_RGMII:
            begin
                er_d = 1'b0;
                if (rise_en)
                begin
                    hold_d = I_LINE_RX;
                    rxd_d  = {PHYMR_NIB_ZERO, I_LINE_RX.data[3:0]};
                    dv_d   = I_LINE_RX.valid;
                end
                else if (fall_en)
                begin
                    rxd_d = {PHYMR_NIB_ZERO, hold_q.data[7:4]};
                    dv_d  = hold_q.valid ^ hold_q.err;
                end
            end
            default:
            begin
                rxd_d = PHYMR_BYTE_RST;
                dv_d  = 1'b0;
                er_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            hold_q <= '0;
            rxd_q  <= PHYMR_BYTE_RST;
            dv_q   <= 1'b0;
            er_q   <= 1'b0;
        end
        else
        begin
            hold_q <= hold_d;
            rxd_q  <= rxd_d;
            dv_q   <= dv_d;
            er_q   <= er_d;
        end
    end

    assign O_RXD        = rxd_q;
    assign O_RX_DV_CTRL = dv_q;
    assign O_RX_ER      = er_q;

    // =====================================================
    // transmit pin synchronisers
    logic [2:0] gtx_s_q;
    logic [1:0] ctl_s_q;
    logic [1:0] ter_s_q;
    logic [7:0] txd_s1_q;
    logic [7:0] txd_s2_q;

    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            gtx_s_q  <= 3'h0;
            ctl_s_q  <= 2'h0;
            ter_s_q  <= 2'h0;
            txd_s1_q <= PHYMR_BYTE_RST;
            txd_s2_q <= PHYMR_BYTE_RST;
        end
        else
        begin
            gtx_s_q  <= {gtx_s_q[1:0], I_GTX_CLK};
            ctl_s_q  <= {ctl_s_q[0], I_TX_EN_CTRL};
            ter_s_q  <= {ter_s_q[0], I_TX_ER};
            txd_s1_q <= I_TXD;
            txd_s2_q <= txd_s1_q;
        end
    end

    logic gtx_rise;
    logic gtx_fall;
    assign gtx_rise = gtx_s_q[1] & ~gtx_s_q[2];
    assign gtx_fall = ~gtx_s_q[1] & gtx_s_q[2];

    // =====================================================
    // transmit decode
    phymr_tx_word_t tx_q;
    phymr_tx_word_t tx_d;
    logic           stb_d;
    logic           stb_q;
    logic           first_en_q;
    logic           first_en_d;
    logic [3:0]     first_nib_q;
    logic [3:0]     first_nib_d;

    always_comb
    begin
        tx_d        = tx_q;
        stb_d       = 1'b0;
        first_en_d  = first_en_q;
        first_nib_d = first_nib_q;
        case (I_MODE)
            PHYMR_MII:
            begin
                if (fall_en)
                begin
                    tx_d.en   = ctl_s_q[1];
                    tx_d.er   = ter_s_q[1];
                    tx_d.data = {PHYMR_NIB_ZERO, txd_s2_q[3:0]};
                    stb_d     = 1'b1;
                end
            end
            PHYMR_GMII:
            begin
                if (gtx_rise)
                begin
                    tx_d.en   = ctl_s_q[1];
                    tx_d.er   = ter_s_q[1];
                    tx_d.data = txd_s2_q;
                    stb_d     = 1'b1;
                end
            end
            PHYMR_RGMII:
            begin
                if (gtx_rise)
                begin
                    first_en_d  = ctl_s_q[1];
                    first_nib_d = txd_s2_q[3:0];
                end
                else if (gtx_fall)
                begin
                    tx_d.en   = first_en_q;
                    tx_d.er   = first_en_q ^ ctl_s_q[1];
                    tx_d.data = {txd_s2_q[3:0], first_nib_q};
                    stb_d     = 1'b1;
                end
            end
            default:
            begin
                tx_d = '0;
            end
        endcase
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            tx_q        <= '0;
            stb_q       <= 1'b0;
            first_en_q  <= 1'b0;
            first_nib_q <= PHYMR_NIB_ZERO;
        end
        else
        begin
            tx_q        <= tx_d;
            stb_q       <= stb_d;
            first_en_q  <= first_en_d;
            first_nib_q <= first_nib_d;
        end
    end

    assign O_TX        = tx_q;
    assign O_TX_STROBE = stb_q;

    // =====================================================
    // collision and carrier sense
    logic col_q;
    logic col_d;
    logic crs_q;
    logic crs_d;
    logic rx_act;
    logic tx_act;

    assign rx_act = I_LINE_RX.carrier;
    assign tx_act = tx_q.en;

    always_comb
    begin
        col_d = 1'b0;
        crs_d = 1'b0;
        if (I_MODE != PHYMR_RGMII)
        begin
            if (!I_FULL_DUPLEX)
            begin
                col_d = rx_act & tx_act;
                crs_d = rx_act | tx_act;
            end
            else if (I_SPEED != PHYMR_S1000)
            begin
                crs_d = rx_act;
            end
        end
    end

    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            col_q <= 1'b0;
            crs_q <= 1'b0;
        end
        else
        begin
            col_q <= col_d;
            crs_q <= crs_d;
        end
    end

    assign O_COL = col_q;
    assign O_CRS = crs_q;

endmodule

// *** phymr_pkg.sv ***
/*
 * shared types and constants for the phy mac-side receive and control block.
 * assumes a 200 MHz system clock; all times are in ns.
 */
package phymr_pkg;

    // =====================================================
    // modes and speeds
    typedef enum logic [1:0] {PHYMR_MII, PHYMR_GMII, PHYMR_RGMII} phymr_mode_t;
    typedef enum logic [1:0] {PHYMR_S10, PHYMR_S100, PHYMR_S1000} phymr_speed_t;

    // =====================================================
    // widths and reset values
    localparam int          PHYMR_BYTE_W   = 8;
    localparam int          PHYMR_NIB_W    = 4;
    localparam int          PHYMR_DIV_W    = 8;
    localparam logic [7:0]  PHYMR_BYTE_RST = 8'h00;
    localparam logic [3:0]  PHYMR_NIB_ZERO = 4'h0;
    localparam logic [7:0]  PHYMR_DIV_ZERO = 8'h00;
    localparam logic [7:0]  PHYMR_DIV_ONE  = 8'h01;

    // =====================================================
    // timing
    localparam int PHYMR_MCLK_NS      = 5;
    localparam int PHYMR_CLK10_NS     = 400;
    localparam int PHYMR_CLK100_NS    = 40;
    localparam int PHYMR_CLK1000_NS   = 8;

    // half period in system cycles, rounded down, never below one
    function automatic int phymr_half_cyc(input int period_ns);
        int h;
        h = (period_ns / 2) / PHYMR_MCLK_NS;
        return (h < 1) ? 1 : h;
    endfunction

    localparam int PHYMR_HALF10   = phymr_half_cyc(PHYMR_CLK10_NS);
    localparam int PHYMR_HALF100  = phymr_half_cyc(PHYMR_CLK100_NS);
    localparam int PHYMR_HALF1000 = phymr_half_cyc(PHYMR_CLK1000_NS);

    // =====================================================
    // carriers
    typedef struct packed {
        logic       valid;
        logic       err;
        logic       carrier;
        logic [7:0] data;
    } phymr_rx_line_t;

    typedef struct packed {
        logic       en;
        logic       er;
        logic [7:0] data;
    } phymr_tx_word_t;

endpackage

// *** phymr_asserts.sv ***
/* port checker for phymr_top.
   assumes static mode/speed/duplex, changed only under reset. */
`timescale 1ns/1ps
module phymr_asserts
    import phymr_pkg::*;
#(
    parameter int HALF10   = phymr_pkg::PHYMR_HALF10,
    parameter int HALF100  = phymr_pkg::PHYMR_HALF100,
    parameter int HALF1000 = phymr_pkg::PHYMR_HALF1000
)(
    // clock, reset, config
    input wire logic                      I_MCLK,
    input wire logic                      I_SYS_RST,
    input wire phymr_pkg::phymr_mode_t    I_MODE,
    input wire phymr_pkg::phymr_speed_t   I_SPEED,
    input wire logic                      I_FULL_DUPLEX,
    // line and transmit side
    input wire phymr_pkg::phymr_rx_line_t I_LINE_RX,
    input wire phymr_pkg::phymr_tx_word_t O_TX,
    input wire logic                      O_TX_STROBE,
    // mac pins
    input wire logic                      O_RX_CLK,
    input wire logic                      O_TX_CLK,
    input wire logic [7:0]                O_RXD,
    input wire logic                      O_RX_DV_CTRL,
    input wire logic                      O_RX_ER,
    input wire logic                      O_COL,
    input wire logic                      O_CRS
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);
    // =====================================================
    // helpers
    wire  rg  = (I_MODE == PHYMR_RGMII);
    wire  both = I_LINE_RX.carrier && O_TX.en;
    wire  any  = I_LINE_RX.carrier || O_TX.en;
    logic       clk_q, seen_q, seen_d;
    logic [7:0] hcnt_q, hcnt_d;
    int         half;
    assign half = (I_SPEED == PHYMR_S10) ? HALF10 : (I_SPEED == PHYMR_S100) ? HALF100 : HALF1000;
    always_comb
    begin
        hcnt_d = (O_RX_CLK != clk_q) ? 8'h00 : hcnt_q + 8'h01;
        seen_d = seen_q | (O_RX_CLK != clk_q);
    end
    always_ff @(posedge I_MCLK)
    begin
        clk_q  <= I_SYS_RST ? 1'b0 : O_RX_CLK;
        hcnt_q <= I_SYS_RST ? 8'h00 : hcnt_d;
        seen_q <= I_SYS_RST ? 1'b0 : seen_d;
    end
    // =====================================================
    // assertions
    rgmii_idle_a: assert property (rg |-> !O_RX_ER && !O_COL && !O_CRS)
        else $error("unused pin active in rgmii");
    upper_nib_a: assert property (I_MODE != PHYMR_GMII |-> O_RXD[7:4] == 4'h0)
        else $error("rx upper bits outside gmii");
    fd_col_a: assert property (I_FULL_DUPLEX |-> !O_COL)
        else $error("collision in full duplex");
    col_cause_a: assert property (!I_FULL_DUPLEX && !rg |=> O_COL == $past(both))
        else $error("collision not tied to activity");
    crs_half_a: assert property (!I_FULL_DUPLEX && !rg |=> O_CRS == $past(any))
        else $error("half duplex carrier sense wrong");
    crs_full_a: assert property (I_FULL_DUPLEX && !rg && I_SPEED != PHYMR_S1000
        |=> O_CRS == $past(I_LINE_RX.carrier))
        else $error("full duplex carrier sense wrong");
    rx_sync_a: assert property ($changed(O_RXD) || $changed(O_RX_DV_CTRL)
        |-> $changed(O_RX_CLK))
        else $error("rx data moved off clock edge");
    rxer_fall_a: assert property (!rg && $changed(O_RX_ER) |-> $fell(O_RX_CLK))
        else $error("rx error moved off falling edge");
    strobe_one_a: assert property (O_TX_STROBE |=> !O_TX_STROBE)
        else $error("tx strobe longer than one cycle");
    tx_clk_a: assert property (O_TX_CLK == (I_MODE == PHYMR_MII && O_RX_CLK))
        else $error("tx clock wrong for mode");
    rx_half_a: assert property (seen_q && O_RX_CLK != clk_q |-> hcnt_q == half - 1)
        else $error("rx clock half period wrong");
    cover property (O_COL);
    cover property (O_TX_STROBE && O_TX.er);
    cover property (rg && $rose(O_RX_CLK) && O_RX_DV_CTRL);
endmodule
bind phymr_top phymr_asserts #(.HALF10(HALF10), .HALF100(HALF100), .HALF1000(HALF1000)) u_chk (
    .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_MODE(I_MODE), .I_SPEED(I_SPEED),
    .I_FULL_DUPLEX(I_FULL_DUPLEX), .I_LINE_RX(I_LINE_RX), .O_TX(O_TX),
    .O_TX_STROBE(O_TX_STROBE), .O_RX_CLK(O_RX_CLK), .O_TX_CLK(O_TX_CLK), .O_RXD(O_RXD),
    .O_RX_DV_CTRL(O_RX_DV_CTRL), .O_RX_ER(O_RX_ER), .O_COL(O_COL), .O_CRS(O_CRS));

// *** phymr_mac_model.sv ***
/* mac transmit side model: gtx clock, enable/control, error, data.
   assumes 48 ns gtx period, clock still and pins pulled low between frames. */
`timescale 1ns/1ps
module phymr_mac_model
    import phymr_pkg::*;
(
    // mac transmit pins
    output logic       o_gtx_clk,
    output logic       o_tx_en_ctrl,
    output logic       o_tx_er,
    output logic [7:0] o_txd
);
    initial
    begin
        o_gtx_clk = 1'b0;
        o_tx_en_ctrl = 1'b0;
        o_tx_er = 1'b0;
        o_txd = 8'h00;
    end
    // one gtx period per word
    task automatic send(input phymr_mode_t m, input phymr_tx_word_t w);
        o_tx_en_ctrl = w.en;
        o_tx_er = (m == PHYMR_RGMII) ? 1'b0 : w.er;
        o_txd = (m == PHYMR_RGMII) ? {4'h0, w.data[3:0]} : w.data;
        #24 o_gtx_clk = 1'b1;
        #12;
        if (m == PHYMR_RGMII)
        begin
            o_tx_en_ctrl = w.en ^ w.er;
            o_txd = {4'h0, w.data[7:4]};
        end
        #12 o_gtx_clk = 1'b0;
    endtask
    // mii: one nibble per tx clock, driven just after its rising edge
    task automatic drive(input phymr_tx_word_t w);
        o_tx_en_ctrl = w.en;
        o_tx_er = w.er;
        o_txd = {4'h0, w.data[3:0]};
    endtask
    // end of frame: pull-downs take the pins
    task automatic idle();
        #24;
        o_tx_en_ctrl = 1'b0;
        o_tx_er = 1'b0;
        o_txd = 8'h00;
    endtask
endmodule

// *** phymr_top_tb.sv ***
/* self-checking bench for phymr_top over all modes, speeds, duplex.
   assumes 5 ns clock and reduced divider halves 4/2/1. */
`timescale 1ns/1ps
`define CHK(n, e, g) \
begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
        error_cnt++; \
        $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
end
module phymr_top_tb;
    import phymr_pkg::*;
    logic           clk = 1'b0, rst = 1'b1, fd = 1'b0;
    phymr_mode_t    mode = PHYMR_MII;
    phymr_speed_t   speed = PHYMR_S10;
    phymr_rx_line_t line = '0, r;
    phymr_tx_word_t otx, tw;
    logic           stb, gtx, en, er, rxclk, txclk, dv, rxer, col, crs;
    logic [7:0]     txd, rxd;
    logic [31:0]    seed, rv;
    logic [1:0]     e;
    int             error_cnt = 0, cmp_count = 0, nstb = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (stb === 1'b1) nstb++;
    logic [1:0]     col_s = 2'b00;
    always @(posedge clk) col_s <= {col_s[0], col};
    phymr_mac_model mac (.o_gtx_clk(gtx), .o_tx_en_ctrl(en), .o_tx_er(er), .o_txd(txd));
    phymr_top #(.HALF10(4), .HALF100(2), .HALF1000(1)) DUT (
        .I_MCLK(clk), .I_SYS_RST(rst), .I_MODE(mode), .I_SPEED(speed),
        .I_FULL_DUPLEX(fd), .I_LINE_RX(line), .O_TX(otx), .O_TX_STROBE(stb),
        .I_GTX_CLK(gtx), .I_TX_EN_CTRL(en), .I_TX_ER(er), .I_TXD(txd),
        .O_RX_CLK(rxclk), .O_TX_CLK(txclk), .O_RXD(rxd), .O_RX_DV_CTRL(dv),
        .O_RX_ER(rxer), .O_COL(col), .O_CRS(crs));
    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // bounded wait for rx clock to reach a level freshly
    task automatic wclk(input logic lvl);
        int n;
        n = 0;
        while (rxclk === lvl && n < 200)
        begin
            @(posedge clk);
            #1 n++;
        end
        while (rxclk !== lvl && n < 200)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 200)
        begin
            error_cnt++;
            stop_test();
        end
    endtask
    function automatic logic [7:0] exp_rxd(input phymr_rx_line_t w);
        return (mode == PHYMR_GMII) ? w.data : {4'h0, w.data[3:0]};
    endfunction
    function automatic logic [1:0] exp_cc(input logic ten, input logic rxa);
        if (mode == PHYMR_RGMII)
            return 2'b00;
        return {!fd && ten && rxa, fd ? rxa : (rxa || ten)};
    endfunction
    task automatic rx_word(input phymr_rx_line_t w);
        line = w;
        if (mode == PHYMR_RGMII)
        begin
            wclk(1'b1);
            `CHK("rxd_rise", {4'h0, w.data[3:0]}, rxd)
            `CHK("ctl_rise", w.valid, dv)
            wclk(1'b0);
            `CHK("rxd_fall", {4'h0, w.data[7:4]}, rxd)
            `CHK("ctl_fall", w.valid ^ w.err, dv)
        end
        else
        begin
            wclk(1'b0);
            `CHK("rxd", exp_rxd(w), rxd)
            `CHK("rx_dv", w.valid, dv)
        end
        `CHK("rx_er", (mode != PHYMR_RGMII) && w.err, rxer)
    endtask
    task automatic tx_word(input phymr_tx_word_t w);
        int n;
        n = 0;
        mac.send(mode, w);
        while (nstb == 0 && n < 20)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 20)
        begin
            error_cnt++;
            stop_test();
        end
        `CHK("tx_word", w, otx)
        nstb = 0;
    endtask
    // mii transmit: pins set after tx clock rise, word seen at its fall
    task automatic mii_word(input phymr_tx_word_t w);
        wclk(1'b1);
        mac.drive(w);
        wclk(1'b0);
        `CHK("mii_tx", {w.en, w.er, 4'h0, w.data[3:0]}, otx)
    endtask
    initial
    begin
        seed = 32'h858FEC92;
        for (int m = 0; m < 3; m++)
            for (int s = 0; s < 3; s++)
                for (int d = 0; d < 2; d++)
                begin
                    rst = 1'b1;
                    mode = phymr_mode_t'(m);
                    speed = phymr_speed_t'(s);
                    fd = d[0];
                    line = '0;
                    repeat (12) @(posedge clk);
                    #1 rst = 1'b0;
                    wclk(1'b0);
                    rx_word({1'b1, 1'b1, 1'b1, 8'hA5});
                    rx_word({1'b0, 1'b1, 1'b0, 8'hFF});
                    repeat (5)
                    begin
                        rv = $random(seed);
                        r = rv[10:0];
                        rx_word(r);
                    end
                    if (mode != PHYMR_MII)
                    begin
                        nstb = 0;
                        repeat (3)
                        begin
                            rv = $random(seed);
                            tw = rv[9:0];
                            tx_word(tw);
                        end
                        tx_word({1'b1, 1'b1, 8'h3C});
                        mac.idle();
                        @(posedge clk);
                        #1;
                    end
                    else if (speed == PHYMR_S10)
                    begin
                        repeat (3)
                        begin
                            rv = $random(seed);
                            tw = rv[9:0];
                            mii_word(tw);
                        end
                        mii_word({1'b0, 1'b0, 8'hF6});
                    end
                    line = {1'b0, 1'b0, 1'b1, 8'h00};
                    repeat (3) @(posedge clk);
                    #1 e = exp_cc(mode != PHYMR_MII, 1'b1);
                    `CHK("col", e[1], col)
                    `CHK("col_sync", e[1], col_s[1])
                    if (!(fd && speed == PHYMR_S1000))
                        `CHK("crs", e[0], crs)
                    $display("test mode %0d speed %0d fd %0d done", m, s, d);
                end
        stop_test();
    end
endmodule
